//--- hw/tc8_cfg.svh
// Constants for the 8-bit timer/counter core: offsets, fields, reset values, counts
`ifndef TC8_CFG_SVH
`define TC8_CFG_SVH

// ==========================================================================
// Register byte offsets on APB
`define TC8_OFS_CTRL_A     8'h00
`define TC8_OFS_CTRL_B     8'h04
`define TC8_OFS_COUNT      8'h08
`define TC8_OFS_CMP_A      8'h0C
`define TC8_OFS_CMP_B      8'h10
`define TC8_OFS_FLAG       8'h14
`define TC8_OFS_MASK       8'h18

// ==========================================================================
// Field positions
`define TC8_CA_WGM_LO      0
`define TC8_CA_WGM_HI      1
`define TC8_CA_OUTEN_B     5
`define TC8_CA_OUTEN_A     7
`define TC8_CB_CS_LO       0
`define TC8_CB_CS_HI       2
`define TC8_CB_WGM2        3
`define TC8_FLG_OVF        0
`define TC8_FLG_MA         1
`define TC8_FLG_MB         2

// ==========================================================================
// Reset values and counter extremes
`define TC8_RST_BYTE       8'h00
`define TC8_RST_FLAGS      3'h0
`define TC8_BOTTOM         8'h00
`define TC8_MAX            8'hFF
`define TC8_ONE            8'h01

// ==========================================================================
// Clock select codes and prescaler taps
`define TC8_CS_STOP        3'h0
`define TC8_CS_DIV1        3'h1
`define TC8_CS_DIV8        3'h2
`define TC8_CS_DIV64       3'h3
`define TC8_CS_DIV256      3'h4
`define TC8_CS_DIV1024     3'h5
`define TC8_CS_EXT_FALL    3'h6
`define TC8_CS_EXT_RISE    3'h7
`define TC8_TAP8           3'h7
`define TC8_TAP64          6'h3F
`define TC8_TAP256         8'hFF
`define TC8_TAP1024        10'h3FF
`define TC8_PRESC_RST      10'h000

`endif

//--- hw/tc8_pkg.sv
// Types shared by the timer/counter core modules
package tc8_pkg;

  // ========================================================================
  // Waveform mode codes
  typedef enum logic [2:0] {
    TC8_WGM_NORMAL   = 3'b000,
    TC8_WGM_PC_MAX   = 3'b001,
    TC8_WGM_CTC      = 3'b010,
    TC8_WGM_FAST_MAX = 3'b011,
    TC8_WGM_RSV4     = 3'b100,
    TC8_WGM_PC_CMPA  = 3'b101,
    TC8_WGM_RSV6     = 3'b110,
    TC8_WGM_FAST_CMPA= 3'b111
  } tc8_wgm_type;

  // ========================================================================
  // Compare unit controls from the counter
  typedef struct packed {
    logic       tick;
    logic       block;
    logic       pwm;
    logic       load;
    logic       fast;
    logic       down;
    logic       wave_set;
    logic [7:0] count;
  } tc8_cmp_ctl_type;

  // Compare unit state
  typedef struct packed {
    logic [7:0] buf_val;
    logic [7:0] act_val;
    logic       oc;
  } tc8_cmp_st_type;

  // Tick selector state
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [9:0] presc;
  } tc8_tick_st_type;

endpackage : tc8_pkg

//--- hw/tc8_tick_sel.sv
// Timer tick source: prescaler taps or synchronised external count pin edges
`timescale 1ns/10ps
`include "tc8_cfg.svh"
module tc8_tick_sel (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] clock_select_field,
  input  wire logic       external_count_pin,
  output logic            timer_tick
);
  import tc8_pkg::*;

  tc8_tick_st_type st_ff;
  tc8_tick_st_type nxt_st;

  // Synchronise pin, track last level, run the prescaler while a source is chosen
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = external_count_pin;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;
    if (clock_select_field == `TC8_CS_STOP) begin
      nxt_st.presc = `TC8_PRESC_RST;
    end else begin
      nxt_st.presc = st_ff.presc + 10'h001;
    end
  end

  // Source and edge choice; stop code gives no tick
  always_comb begin
    unique case (clock_select_field)
      `TC8_CS_STOP:     timer_tick = 1'b0;
      `TC8_CS_DIV1:     timer_tick = 1'b1;
      `TC8_CS_DIV8:     timer_tick = (st_ff.presc[2:0] == `TC8_TAP8);
      `TC8_CS_DIV64:    timer_tick = (st_ff.presc[5:0] == `TC8_TAP64);
      `TC8_CS_DIV256:   timer_tick = (st_ff.presc[7:0] == `TC8_TAP256);
      `TC8_CS_DIV1024:  timer_tick = (st_ff.presc == `TC8_TAP1024);
      `TC8_CS_EXT_FALL: timer_tick = st_ff.prev & ~st_ff.sync2;
      `TC8_CS_EXT_RISE: timer_tick = ~st_ff.prev & st_ff.sync2;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : tc8_tick_sel

//--- hw/tc8_cmp_unit.sv
// One compare unit: buffered compare value, match detect, compare output level
`timescale 1ns/10ps
`include "tc8_cfg.svh"
module tc8_cmp_unit (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     wr_en,
  input  wire logic [7:0]               wr_data,
  input  wire tc8_pkg::tc8_cmp_ctl_type ctl,
  output logic [7:0]                    buf_val,
  output logic [7:0]                    act_val,
  output logic                          match_set,
  output logic                          compare_out
);
  import tc8_pkg::*;

  tc8_cmp_st_type st_ff;
  tc8_cmp_st_type nxt_st;
  logic           hit;

  // Continuous equality; flag set at the tick that follows, unless a count write blocks it
  assign hit       = (ctl.count == st_ff.act_val);
  assign match_set = ctl.tick & hit & ~ctl.block;

  // Buffer in PWM modes, direct update otherwise; output follows matches
  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.buf_val = wr_data;
      if (!ctl.pwm) begin
        nxt_st.act_val = wr_data;
      end
    end
    if (ctl.pwm && ctl.load) begin
      nxt_st.act_val = st_ff.buf_val;
    end
    if (ctl.wave_set) begin
      nxt_st.oc = 1'b1;
    end else if (match_set) begin
      if (!ctl.pwm) begin
        nxt_st.oc = ~st_ff.oc;
      end else if (ctl.fast) begin
        nxt_st.oc = 1'b0;
      end else begin
        nxt_st.oc = ctl.down;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign buf_val     = st_ff.buf_val;
  assign act_val     = st_ff.act_val;
  assign compare_out = st_ff.oc;

endmodule : tc8_cmp_unit

//--- hw/tc8_timer8_counter_core.sv
// 8-bit timer/counter core with APB registers, two compare units and three flags
//
// Operation
// - Two compare units, three interrupt sources.
// - Count and compare registers are 8 bits.
// - Requests appear as flags, each individually masked.
// - Tick from prescaler or external pin edge.
// - Three-bit clock select in control B.
// - Select zero stops counter, value held.
// - Buffered compare values compared every cycle.
// - Compare result drives waveform output pins.
// - Bottom is 0x00, max is 0xFF.
// - Top is 0xFF or compare A.
// - Tick clears, increments or decrements the count.
// - Clear zeroes count; top/bottom indications exist.
// - Software reads/writes count anytime.
// - Software count write beats clear/count.
// - Mode bits split across both control registers.
// - Overflow flag set per mode, maskable request.
// - Mode 0 wraps, overflow with zero.
// - Mode 2 clears on compare A match.
// - Match flag set next tick; ack/write-one clears.
// - Count write blocks next-tick compare match.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "tc8_cfg.svh"
module tc8_timer8_counter_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_count_pin,
  input  wire logic [2:0]  irq_ack,
  output logic [2:0]       irq_req,
  output logic             compare_out_a_pin,
  output logic             compare_out_b_pin,
  output logic             compare_out_a_en,
  output logic             compare_out_b_en
);
  import tc8_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0]  count_value_reg;
    logic        down;
    logic [7:0]  timer_control_a_reg;
    logic [7:0]  timer_control_b_reg;
    logic [2:0]  timer_flag_reg;
    logic [2:0]  timer_mask_reg;
    logic        block;
    logic [31:0] rdata;
  } tc8_core_st_type;

  tc8_core_st_type st_ff;
  tc8_core_st_type nxt_st;

  logic            timer_tick;
  logic [2:0]      clock_select_field;
  tc8_wgm_type     waveform_mode_field;
  logic            mode_pwm;
  logic            mode_fast;
  logic            mode_pc;
  logic [7:0]      top_val;
  logic            at_top;
  logic            at_bottom;
  logic            at_max;
  logic            wr_acc;
  logic            rd_setup;
  logic            addr_hit;
  logic            wr_count;
  logic            wr_cmp_a;
  logic            wr_cmp_b;
  logic            ovf_set;
  logic            ma_set;
  logic            mb_set;
  logic [2:0]      flag_clr;
  logic [7:0]      cmp_a_buf;
  logic [7:0]      cmp_a_act;
  logic [7:0]      cmp_b_buf;
  logic [7:0]      cmp_b_act;
  logic [31:0]     rd_mux;
  tc8_cmp_ctl_type cmp_ctl;

  // ========================================================================
  // Mode decode
  //   0, 4, 6: count up, max wraps
  //   1: phase correct, top at max
  //   2: clear on compare A match
  //   3: fast PWM, top at max
  //   5: phase correct, top is A
  //   7: fast PWM, top is A
  //   Bit 2 in control B, 1:0 in A
  assign clock_select_field  = st_ff.timer_control_b_reg[`TC8_CB_CS_HI:`TC8_CB_CS_LO];
  assign waveform_mode_field = tc8_wgm_type'({st_ff.timer_control_b_reg[`TC8_CB_WGM2],
                                 st_ff.timer_control_a_reg[`TC8_CA_WGM_HI:`TC8_CA_WGM_LO]});
  assign mode_fast = (waveform_mode_field == TC8_WGM_FAST_MAX) ||
                     (waveform_mode_field == TC8_WGM_FAST_CMPA);
  assign mode_pc   = (waveform_mode_field == TC8_WGM_PC_MAX) ||
                     (waveform_mode_field == TC8_WGM_PC_CMPA);
  assign mode_pwm  = mode_fast | mode_pc;

  // Top, bottom and max indications
  // Modes with bit 2 set take A as top
  assign top_val   = waveform_mode_field[2] ? cmp_a_act : `TC8_MAX;
  assign at_top    = (st_ff.count_value_reg == top_val);
  assign at_bottom = (st_ff.count_value_reg == `TC8_BOTTOM);
  assign at_max    = (st_ff.count_value_reg == `TC8_MAX);

  // ========================================================================
  // APB decode; zero wait states
  //   0x00 control A, 0x04 control B
  //   0x08 count, 0x0C/0x10 compare
  //   0x14 flags, write one clears
  //   0x18 mask, same bit order
  //   Others: error, read zero
  //   Upper data bits read zero
  //   Read data caught in setup,
  //   stands through access
  assign pready   = 1'b1;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    unique case (paddr)
      `TC8_OFS_CTRL_A: rd_mux[7:0] = st_ff.timer_control_a_reg;
      `TC8_OFS_CTRL_B: rd_mux[7:0] = st_ff.timer_control_b_reg;
      `TC8_OFS_COUNT:  rd_mux[7:0] = st_ff.count_value_reg;
      `TC8_OFS_CMP_A:  rd_mux[7:0] = cmp_a_buf;
      `TC8_OFS_CMP_B:  rd_mux[7:0] = cmp_b_buf;
      `TC8_OFS_FLAG:   rd_mux[2:0] = st_ff.timer_flag_reg;
      `TC8_OFS_MASK:   rd_mux[2:0] = st_ff.timer_mask_reg;
      default:         addr_hit    = 1'b0;
    endcase
  end
  assign pslverr  = psel & penable & ~addr_hit;
  assign prdata   = st_ff.rdata;
  assign wr_count = wr_acc & (paddr == `TC8_OFS_COUNT);
  assign wr_cmp_a = wr_acc & (paddr == `TC8_OFS_CMP_A);
  assign wr_cmp_b = wr_acc & (paddr == `TC8_OFS_CMP_B);

  // ========================================================================
  // Overflow condition per mode
  //   Phase correct: bottom, down
  //   Fast PWM: wrap at top
  //   Others: wrap from max
  //   All on a tick only
  always_comb begin
    if (mode_pc) begin
      ovf_set = timer_tick & at_bottom & st_ff.down;
    end else if (mode_fast) begin
      ovf_set = timer_tick & at_top;
    end else begin
      ovf_set = timer_tick & at_max;
    end
  end

  // Write-one or interrupt acknowledge clears a flag
  // Acknowledge is a one-cycle pulse
  assign flag_clr = irq_ack | ((wr_acc && paddr == `TC8_OFS_FLAG) ? pwdata[2:0] : 3'h0);

  // ========================================================================
  // Next state: registers, counter, flags, read data
  // Writes land in the access cycle
  always_comb begin
    nxt_st = st_ff;
    if (rd_setup) begin
      nxt_st.rdata = rd_mux;
    end
    if (wr_acc && paddr == `TC8_OFS_CTRL_A) begin
      nxt_st.timer_control_a_reg = pwdata[7:0];
    end
    if (wr_acc && paddr == `TC8_OFS_CTRL_B) begin
      nxt_st.timer_control_b_reg = pwdata[7:0];
    end
    if (wr_acc && paddr == `TC8_OFS_MASK) begin
      nxt_st.timer_mask_reg = pwdata[2:0];
    end
    // Block survives until the next tick has passed
    // Stopped timer keeps it armed, so a
    // start cannot match the new value
    if (wr_count) begin
      nxt_st.block = 1'b1;
    end else if (timer_tick) begin
      nxt_st.block = 1'b0;
    end
    // Counter: software write first, then tick action by mode
    // A write beats any tick action
    // Turning ticks step the other way,
    // so top and bottom last one tick
    if (wr_count) begin
      nxt_st.count_value_reg = pwdata[7:0];
    end else if (timer_tick) begin
      if (mode_pc) begin
        if (!st_ff.down) begin
          if (at_top) begin
            nxt_st.down            = 1'b1;
            nxt_st.count_value_reg = st_ff.count_value_reg - `TC8_ONE;
          end else begin
            nxt_st.count_value_reg = st_ff.count_value_reg + `TC8_ONE;
          end
        end else begin
          if (at_bottom) begin
            nxt_st.down            = 1'b0;
            nxt_st.count_value_reg = st_ff.count_value_reg + `TC8_ONE;
          end else begin
            nxt_st.count_value_reg = st_ff.count_value_reg - `TC8_ONE;
          end
        end
      end else if (mode_fast && at_top) begin
        nxt_st.count_value_reg = `TC8_BOTTOM;
      end else if (waveform_mode_field == TC8_WGM_CTC &&
                   st_ff.count_value_reg == cmp_a_act) begin
        nxt_st.count_value_reg = `TC8_BOTTOM;
      end else begin
        nxt_st.count_value_reg = st_ff.count_value_reg + `TC8_ONE;
      end
    end
    if (!mode_pc) begin
      nxt_st.down = 1'b0;
    end
    // Set wins over clear
    // so no event is lost to a late
    // acknowledge of the one before
    nxt_st.timer_flag_reg = (st_ff.timer_flag_reg & ~flag_clr) |
                            {mb_set, ma_set, ovf_set};
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ========================================================================
  // Tick source
  //   Pin passes two flops first
  //   Stop code gives no tick
  tc8_tick_sel u_tick (
    .pclk               (pclk),
    .presetn            (presetn),
    .clock_select_field (clock_select_field),
    .external_count_pin (external_count_pin),
    .timer_tick         (timer_tick)
  );

  // Controls shared by both compare units
  // Buffered values load at the top
  // tick, in the PWM modes only
  always_comb begin
    cmp_ctl          = '0;
    cmp_ctl.tick     = timer_tick;
    cmp_ctl.block    = st_ff.block;
    cmp_ctl.pwm      = mode_pwm;
    cmp_ctl.load     = timer_tick & at_top;
    cmp_ctl.fast     = mode_fast;
    cmp_ctl.down     = st_ff.down;
    cmp_ctl.wave_set = timer_tick & mode_fast & at_top;
    cmp_ctl.count    = st_ff.count_value_reg;
  end

  // Two compare units
  //   One count, tick and block
  tc8_cmp_unit u_cmp_a (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (wr_cmp_a),
    .wr_data     (pwdata[7:0]),
    .ctl         (cmp_ctl),
    .buf_val     (cmp_a_buf),
    .act_val     (cmp_a_act),
    .match_set   (ma_set),
    .compare_out (compare_out_a_pin)
  );

  tc8_cmp_unit u_cmp_b (
    .pclk        (pclk),
    .presetn     (presetn),
    .wr_en       (wr_cmp_b),
    .wr_data     (pwdata[7:0]),
    .ctl         (cmp_ctl),
    .buf_val     (cmp_b_buf),
    .act_val     (cmp_b_act),
    .match_set   (mb_set),
    .compare_out (compare_out_b_pin)
  );

  // Masked requests and output enables
  // Pins show the compare level
  // whether enabled or not
  assign irq_req          = st_ff.timer_flag_reg & st_ff.timer_mask_reg;
  assign compare_out_a_en = st_ff.timer_control_a_reg[`TC8_CA_OUTEN_A];
  assign compare_out_b_en = st_ff.timer_control_a_reg[`TC8_CA_OUTEN_B];

endmodule : tc8_timer8_counter_core

//--- dv/tc8_core_chk.sv
// Port-level checker for the 8-bit timer/counter core
`timescale 1ns/10ps
`include "tc8_cfg.svh"
module tc8_core_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        external_count_pin,
  input wire logic [2:0]  irq_ack,
  input wire logic [2:0]  irq_req,
  input wire logic        compare_out_a_pin,
  input wire logic        compare_out_b_pin,
  input wire logic        compare_out_a_en,
  input wire logic        compare_out_b_en
);
  import tc8_pkg::*;

  // ==========================================================================
  // Shadow copies of software-written registers
  logic       wr_go;
  logic       rd_go;
  logic       mapped;
  logic [7:0] cmpa_ff;
  logic [7:0] ctla_ff;
  logic [2:0] mask_ff;
  logic [2:0] cs_ff;

  // Decode of the current access
  assign wr_go  = psel & penable & pwrite;
  assign rd_go  = psel & penable & ~pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= `TC8_OFS_MASK);

  // Shadows follow completed writes, so reads can be predicted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_ff <= 8'h00;
      ctla_ff <= 8'h00;
      mask_ff <= 3'h0;
      cs_ff   <= 3'h0;
    end else if (wr_go) begin
      if (paddr == `TC8_OFS_CMP_A) cmpa_ff <= pwdata[7:0];
      if (paddr == `TC8_OFS_CTRL_A) ctla_ff <= pwdata[7:0];
      if (paddr == `TC8_OFS_MASK) mask_ff <= pwdata[2:0];
      if (paddr == `TC8_OFS_CTRL_B) cs_ff <= pwdata[2:0];
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ready;
    psel |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low in a transfer");
  property p_slverr;
    psel && penable |-> (pslverr == !mapped);
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_unmap_rd;
    rd_go && !mapped |-> prdata == 32'h0;
  endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
  property p_cmpa_rd;
    rd_go && paddr == `TC8_OFS_CMP_A |-> prdata == {24'h0, cmpa_ff};
  endproperty
  a_cmpa_rd: assert property (p_cmpa_rd) else $error("compare A readback wrong");
  property p_mask_rd;
    rd_go && paddr == `TC8_OFS_MASK |-> prdata == {29'h0, mask_ff};
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  property p_req_mask;
    (irq_req & ~mask_ff) == 3'h0;
  endproperty
  a_req_mask: assert property (p_req_mask) else $error("request through mask");
  property p_stop_quiet;
    cs_ff == 3'h0 && $past(cs_ff) == 3'h0 && $past(cs_ff, 2) == 3'h0 && $stable(mask_ff)
      |-> (irq_req & ~$past(irq_req)) == 3'h0;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("flag set while stopped");
  property p_ack_clr;
    (|irq_ack) && cs_ff == 3'h0 && $past(cs_ff) == 3'h0 |=> (irq_req & $past(irq_ack)) == 3'h0;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack did not clear");
  property p_rst;
    $rose(presetn) |-> irq_req == 3'h0 && !compare_out_a_en && !compare_out_b_en
      && !compare_out_a_pin && !compare_out_b_pin;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_out_en;
    compare_out_a_en == ctla_ff[7] && compare_out_b_en == ctla_ff[5];
  endproperty
  a_out_en: assert property (p_out_en) else $error("output enable wrong");

  // Main scenarios reached
  c_ovf: cover property ($rose(irq_req[0]));
  c_match_a: cover property ($rose(irq_req[1]));
  c_err: cover property (pslverr);
  c_ack: cover property (|irq_ack);
endmodule : tc8_core_chk

bind tc8_timer8_counter_core tc8_core_chk chk_u (
  .pclk               (pclk),
  .presetn            (presetn),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .prdata             (prdata),
  .pready             (pready),
  .pslverr            (pslverr),
  .external_count_pin (external_count_pin),
  .irq_ack            (irq_ack),
  .irq_req            (irq_req),
  .compare_out_a_pin  (compare_out_a_pin),
  .compare_out_b_pin  (compare_out_b_pin),
  .compare_out_a_en   (compare_out_a_en),
  .compare_out_b_en   (compare_out_b_en)
);

//--- dv/tc8_tb.sv
// Self-checking testbench for the 8-bit timer/counter core
`timescale 1ns/10ps
`include "tc8_cfg.svh"
module testbench;
  import tc8_pkg::*;

  // ==========================================================================
  // Signals
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        external_count_pin;
  logic [2:0]  irq_ack;
  logic [2:0]  irq_req;
  logic        compare_out_a_pin;
  logic        compare_out_b_pin;
  logic [31:0] rd;
  int          fail_count;
  int          comparisons;
  int          dv[5] = '{1, 8, 64, 256, 1024};

  tc8_timer8_counter_core dut_u (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .external_count_pin (external_count_pin),
    .irq_ack            (irq_ack),
    .irq_req            (irq_req),
    .compare_out_a_pin  (compare_out_a_pin),
    .compare_out_b_pin  (compare_out_b_pin),
    .compare_out_a_en   (),
    .compare_out_b_en   ()
  );

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rchk

  // Read a count, within two of the figure
  task automatic near(input logic [7:0] a, input int e);
    xfer(1'b0, a, 32'h0);
    chk((^rd !== 1'bx && int'(rd) - e <= 2 && e - int'(rd) <= 2) ? 32'(e) : rd, 32'(e));
  endtask : near

  // Wait at falling edges for a request line, bounded
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (irq_req[b] !== 1'b1 && n < 600);
    chk({31'h0, irq_req[b]}, 32'h1);
  endtask : wait_irq

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    external_count_pin = 1'b0;
    irq_ack = 3'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 28; a += 4) rchk(8'(a), 32'h0);
    wr(`TC8_OFS_CMP_A, 32'hFFFFFF5A);
    rchk(`TC8_OFS_CMP_A, 32'h5A);
    wr(`TC8_OFS_MASK, 32'hFFFFFFFF);
    rchk(`TC8_OFS_MASK, 32'h7);
    wr(8'h1C, 32'hFF);
    rchk(8'h1C, 32'h0);
    wr(`TC8_OFS_MASK, 32'h1);
    wr(`TC8_OFS_COUNT, 32'h33);
    repeat (20) @(posedge pclk);
    rchk(`TC8_OFS_COUNT, 32'h33);
    // Normal mode wrap with overflow and match B
    wr(`TC8_OFS_CMP_B, 32'h2);
    wr(`TC8_OFS_COUNT, 32'hF8);
    wr(`TC8_OFS_CTRL_B, 32'h1);
    wait_irq(0);
    rchk(`TC8_OFS_COUNT, 32'h1);
    wr(`TC8_OFS_CTRL_B, 32'h0);
    rchk(`TC8_OFS_FLAG, 32'h5);
    // Flag clears by execution and by writing one
    @(posedge pclk);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    rchk(`TC8_OFS_FLAG, 32'h4);
    wr(`TC8_OFS_FLAG, 32'h4);
    rchk(`TC8_OFS_FLAG, 32'h0);
    // Count write wins over a running count
    wr(`TC8_OFS_CTRL_B, 32'h1);
    wr(`TC8_OFS_COUNT, 32'h80);
    rchk(`TC8_OFS_COUNT, 32'h81);
    wr(`TC8_OFS_CTRL_B, 32'h0);
    // Count write hides the match on the next tick
    wr(`TC8_OFS_FLAG, 32'h7);
    wr(`TC8_OFS_CMP_B, 32'h40);
    wr(`TC8_OFS_COUNT, 32'h40);
    wr(`TC8_OFS_CTRL_B, 32'h1);
    wr(`TC8_OFS_CTRL_B, 32'h0);
    rchk(`TC8_OFS_FLAG, 32'h0);
    // Clear on compare A match, outputs enabled
    wr(`TC8_OFS_COUNT, 32'h0);
    wr(`TC8_OFS_CMP_A, 32'h5);
    wr(`TC8_OFS_CTRL_A, 32'hA2);
    wr(`TC8_OFS_MASK, 32'h2);
    wr(`TC8_OFS_CTRL_B, 32'h1);
    wait_irq(1);
    chk({30'h0, compare_out_a_pin, compare_out_b_pin}, 32'h3);
    rchk(`TC8_OFS_COUNT, 32'h1);
    repeat (100) @(posedge pclk);
    wr(`TC8_OFS_CTRL_B, 32'h0);
    xfer(1'b0, `TC8_OFS_COUNT, 32'h0);
    chk((rd[7:0] <= 8'h05) ? 32'h0 : rd, 32'h0);
    rchk(`TC8_OFS_FLAG, 32'h2);
    // Phase correct mode turns round at the top
    wr(`TC8_OFS_CTRL_A, 32'h1);
    wr(`TC8_OFS_COUNT, 32'h0);
    wr(`TC8_OFS_CTRL_B, 32'h1);
    repeat (300) @(posedge pclk);
    wr(`TC8_OFS_CTRL_B, 32'h0);
    near(`TC8_OFS_COUNT, 510 - 303);
    // Fast PWM wraps at top with overflow
    wr(`TC8_OFS_MASK, 32'h1);
    wr(`TC8_OFS_CTRL_A, 32'h3);
    wr(`TC8_OFS_COUNT, 32'hFD);
    wr(`TC8_OFS_CTRL_B, 32'h1);
    wait_irq(0);
    wr(`TC8_OFS_CTRL_B, 32'h0);
    // Prescaler taps: 2100 idle cycles plus three edges of the stop write
    wr(`TC8_OFS_CTRL_A, 32'h0);
    for (int i = 1; i <= 5; i++) begin
      wr(`TC8_OFS_COUNT, 32'h0);
      wr(`TC8_OFS_CTRL_B, 32'(i));
      repeat (2100) @(posedge pclk);
      wr(`TC8_OFS_CTRL_B, 32'h0);
      near(`TC8_OFS_COUNT, (2103 / dv[i - 1]) % 256);
    end
    // External pin: nine toggles from low give five rises and four falls
    for (int i = 6; i <= 7; i++) begin
      wr(`TC8_OFS_COUNT, 32'h0);
      wr(`TC8_OFS_CTRL_B, 32'(i));
      repeat (9) begin
        repeat (4) @(posedge pclk);
        external_count_pin <= ~external_count_pin;
      end
      repeat (8) @(posedge pclk);
      wr(`TC8_OFS_CTRL_B, 32'h0);
      rchk(`TC8_OFS_COUNT, (i == 7) ? 32'h5 : 32'h4);
      @(posedge pclk);
      external_count_pin <= 1'b0;
    end
    final_report();
  end

  // Watchdog, about three and a half times the run
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    final_report();
  end
endmodule : testbench
